/* File: bos_params.svh */
`ifndef BOS_PARAMS_SVH
`define BOS_PARAMS_SVH

// ----------------------------------------
// opcode bytes
// ----------------------------------------
`define BOS_PREFIX      8'hed
`define BOS_OP_INC_RPT  8'hb3
`define BOS_OP_DEC_ONE  8'hab
`define BOS_OP_DEC_RPT  8'hbb

// ----------------------------------------
// t-states per machine cycle
// ----------------------------------------
`define BOS_T_FETCH_PFX 3'h4
`define BOS_T_FETCH_OP  3'h5
`define BOS_T_MEM_RD    3'h3
`define BOS_T_IO_WR     3'h4
`define BOS_T_REWIND    3'h5

// ----------------------------------------
// arithmetic steps
// ----------------------------------------
`define BOS_STEP8       8'h01
`define BOS_STEP16      16'h0001
`define BOS_PC_REWIND   16'h0002
`define BOS_ZERO8       8'h00
`define BOS_T_ONE       3'h1
`define BOS_T_ZERO      3'h0

`endif

/* File: bos_pkg.sv */
package bos_pkg;

  typedef enum logic [2:0] {
    BOS_IDLE      = 3'h0,
    BOS_FETCH_PFX = 3'h1,
    BOS_FETCH_OP  = 3'h3,
    BOS_MEM_RD    = 3'h2,
    BOS_IO_WR     = 3'h6,
    BOS_REWIND    = 3'h7
  } bos_state_t;

  typedef enum logic [1:0] {
    BOS_K_NONE    = 2'h0,
    BOS_K_INC_RPT = 2'h1,
    BOS_K_DEC_ONE = 2'h2,
    BOS_K_DEC_RPT = 2'h3
  } bos_kind_t;

  typedef struct packed {
    logic [7:0]  count;
    logic [7:0]  port;
    logic [15:0] ptr;
    logic [15:0] pc;
  } bos_regs_t;

  typedef struct packed {
    logic s;
    logic z;
    logic h;
    logic pv;
    logic n;
    logic c;
  } bos_flags_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  dout;
    logic        fetch;
    logic        rfsh;
    logic        mem_rd;
    logic        io_wr;
  } bos_bus_t;

endpackage : bos_pkg

/* File: bos_decode.sv */
`include "bos_params.svh"

module bos_decode
  import bos_pkg::*;
(
  // opcode bytes
  input  wire logic [7:0] prefix_i,
  input  wire logic [7:0] opcode_i,
  // result
  output bos_kind_t       kind_o
);

  always_comb
  begin
    kind_o = BOS_K_NONE;
    if (prefix_i == `BOS_PREFIX)
    begin
      unique case (opcode_i)
        `BOS_OP_INC_RPT: kind_o = BOS_K_INC_RPT;
        `BOS_OP_DEC_ONE: kind_o = BOS_K_DEC_ONE;
        `BOS_OP_DEC_RPT: kind_o = BOS_K_DEC_RPT;
        default:         kind_o = BOS_K_NONE;
      endcase
    end
  end

endmodule : bos_decode

/* File: bos_tstate_ctr.sv */
`include "bos_params.svh"

module bos_tstate_ctr
  import bos_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  // control
  input  wire logic       run_i,
  input  wire logic [2:0] len_i,
  // count
  output logic      [2:0] tcnt_o,
  output logic            last_o
);

  logic [2:0] tcnt_r;
  logic [2:0] tcnt_nxt;

  assign tcnt_o = tcnt_r;
  assign last_o = run_i && (tcnt_r == 3'(len_i - `BOS_T_ONE));

  always_comb
  begin
    if (!run_i || last_o)
      tcnt_nxt = `BOS_T_ZERO;
    else
      tcnt_nxt = 3'(tcnt_r + `BOS_T_ONE);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tcnt_r <= `BOS_T_ZERO;
    else if (ce)
      tcnt_r <= tcnt_nxt;
  end

endmodule : bos_tstate_ctr

/* File: bos_out_seq.sv */
`include "bos_params.svh"

// Contract
// - read memory byte at pointer, hold it
// - decrement count before port write
// - port number on address bits 7..0
// - decremented count on address bits 15..8
// - held byte written to selected port
// - increment repeat adds one to pointer
// - single decrement: pointer minus one, once
// - prefix then b3, ab or bb decode
// - nonzero count rewinds instruction pointer by two; single decrement ab ends instead
// - zero count ends the instruction
// - interrupts and two refreshes per byte
// - starting count zero gives 256 transfers
module bos_out_seq
  import bos_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  // instruction start
  input  wire logic       start_i,
  input  wire logic [7:0] prefix_i,
  input  wire logic [7:0] opcode_i,
  input  bos_regs_t       regs_i,
  input  bos_flags_t      flags_i,
  // processor bus
  input  wire logic [7:0] mem_rdata_i,
  output bos_bus_t        bus_o,
  // interrupt
  input  wire logic       int_req_i,
  output logic            int_ack_o,
  // result
  output logic            busy_o,
  output logic            done_o,
  output bos_regs_t       regs_o,
  output bos_flags_t      flags_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  bos_state_t state_r;
  bos_state_t state_nxt;
  bos_kind_t  kind_r;
  bos_kind_t  kind_nxt;
  bos_kind_t  dec_kind;
  bos_regs_t  regs_r;
  bos_regs_t  regs_nxt;
  bos_flags_t flags_r;
  bos_flags_t flags_nxt;
  bos_bus_t   bus_r;
  bos_bus_t   bus_nxt;
  logic [7:0] byte_r;
  logic [7:0] byte_nxt;
  logic       done_r;
  logic       done_nxt;
  logic       ack_r;
  logic       ack_nxt;
  logic [2:0] len;
  logic [2:0] tcnt;
  logic       last;
  logic       run;
  logic       repeating;
  logic       upward;

  assign run       = (state_r != BOS_IDLE);
  assign repeating = (kind_r != BOS_K_DEC_ONE);
  assign upward    = (kind_r == BOS_K_INC_RPT);
  assign bus_o     = bus_r;
  assign regs_o    = regs_r;
  assign flags_o   = flags_r;
  assign done_o    = done_r;
  assign int_ack_o = ack_r;
  assign busy_o    = run;

  bos_decode u_decode (
    .prefix_i (prefix_i),
    .opcode_i (opcode_i),
    .kind_o   (dec_kind)
  );

  bos_tstate_ctr u_tctr (
    .clk    (clk),
    .arst_n (arst_n),
    .ce     (ce),
    .run_i  (run),
    .len_i  (len),
    .tcnt_o (tcnt),
    .last_o (last)
  );

  // ----------------------------------------
  // machine cycle lengths
  // ----------------------------------------
  always_comb
  begin
    unique case (state_r)
      BOS_FETCH_PFX: len = `BOS_T_FETCH_PFX;
      BOS_FETCH_OP:  len = `BOS_T_FETCH_OP;
      BOS_MEM_RD:    len = `BOS_T_MEM_RD;
      BOS_IO_WR:     len = `BOS_T_IO_WR;
      BOS_REWIND:    len = `BOS_T_REWIND;
      default:       len = `BOS_T_ONE;
    endcase
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    kind_nxt  = kind_r;
    regs_nxt  = regs_r;
    flags_nxt = flags_r;
    byte_nxt  = byte_r;
    done_nxt  = 1'b0;
    ack_nxt   = 1'b0;
    unique case (state_r)
      BOS_IDLE:
      begin
        if (start_i && dec_kind != BOS_K_NONE)
        begin
          kind_nxt  = dec_kind;
          regs_nxt  = regs_i;
          flags_nxt = flags_i;
          state_nxt = BOS_FETCH_PFX;
        end
      end
      BOS_FETCH_PFX:
      begin
        if (last)
        begin
          regs_nxt.pc = 16'(regs_r.pc + `BOS_STEP16);
          state_nxt   = BOS_FETCH_OP;
        end
      end
      BOS_FETCH_OP:
      begin
        if (last)
        begin
          regs_nxt.pc = 16'(regs_r.pc + `BOS_STEP16);
          state_nxt   = BOS_MEM_RD;
        end
      end
      BOS_MEM_RD:
      begin
        if (last)
        begin
          byte_nxt       = mem_rdata_i;
          regs_nxt.count = 8'(regs_r.count - `BOS_STEP8);
          state_nxt      = BOS_IO_WR;
        end
      end
      BOS_IO_WR:
      begin
        if (last)
        begin
          if (upward)
            regs_nxt.ptr = 16'(regs_r.ptr + `BOS_STEP16);
          else
            regs_nxt.ptr = 16'(regs_r.ptr - `BOS_STEP16);
          flags_nxt.z = (regs_r.count == `BOS_ZERO8);
          flags_nxt.n = 1'b1;
          if (!repeating || regs_r.count == `BOS_ZERO8)
          begin
            done_nxt  = 1'b1;
            state_nxt = BOS_IDLE;
          end
          else
            state_nxt = BOS_REWIND;
        end
      end
      BOS_REWIND:
      begin
        if (last)
        begin
          regs_nxt.pc = 16'(regs_r.pc - `BOS_PC_REWIND);
          if (int_req_i)
          begin
            ack_nxt   = 1'b1;
            done_nxt  = 1'b1;
            state_nxt = BOS_IDLE;
          end
          else
            state_nxt = BOS_FETCH_PFX;
        end
      end
      default:
        state_nxt = BOS_IDLE;
    endcase
  end

  // ----------------------------------------
  // bus drive from next state
  // ----------------------------------------
  always_comb
  begin
    bus_nxt = '0;
    unique case (state_nxt)
      BOS_FETCH_PFX, BOS_FETCH_OP:
      begin
        bus_nxt.addr  = regs_nxt.pc;
        bus_nxt.fetch = 1'b1;
        bus_nxt.rfsh  = (state_nxt == state_r) && last == 1'b0 && (tcnt >= `BOS_T_ONE);
      end
      BOS_MEM_RD:
      begin
        bus_nxt.addr   = regs_nxt.ptr;
        bus_nxt.mem_rd = 1'b1;
      end
      BOS_IO_WR:
      begin
        bus_nxt.addr  = {regs_nxt.count, regs_nxt.port};
        bus_nxt.dout  = byte_nxt;
        bus_nxt.io_wr = 1'b1;
      end
      default:
        bus_nxt = '0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= BOS_IDLE;
      kind_r  <= BOS_K_NONE;
      regs_r  <= '0;
      flags_r <= '0;
      bus_r   <= '0;
      byte_r  <= `BOS_ZERO8;
      done_r  <= 1'b0;
      ack_r   <= 1'b0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
      regs_r  <= regs_nxt;
      flags_r <= flags_nxt;
      bus_r   <= bus_nxt;
      byte_r  <= byte_nxt;
      done_r  <= done_nxt;
      ack_r   <= ack_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_rd_end;
    ce && state_r == BOS_MEM_RD && last;
  endsequence

  sequence s_wr_end;
    ce && state_r == BOS_IO_WR && last;
  endsequence

  property p_hold_byte;
    s_rd_end ##1 (state_r == BOS_IO_WR) [*1] |-> byte_r == $past(mem_rdata_i);
  endproperty
  a_hold_byte: assert property (p_hold_byte) else $error("read byte not held");

  property p_count_dec;
    s_rd_end |=> regs_r.count == 8'($past(regs_r.count) - 8'h01);
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count not decremented");

  property p_wrap;
    s_rd_end ##0 (regs_r.count == 8'h00) |=> regs_r.count == 8'hff;
  endproperty
  a_wrap: assert property (p_wrap) else $error("zero count did not wrap");

  property p_port_addr;
    bus_r.io_wr |-> bus_r.addr == {regs_r.count, regs_r.port} && bus_r.dout == byte_r;
  endproperty
  a_port_addr: assert property (p_port_addr) else $error("port write address or data wrong");

  property p_ptr_step;
    s_wr_end |=> regs_r.ptr == (kind_r == BOS_K_INC_RPT ? 16'($past(regs_r.ptr) + 16'h0001)
                                                        : 16'($past(regs_r.ptr) - 16'h0001));
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer step wrong");

  property p_single_once;
    s_wr_end ##0 (kind_r == BOS_K_DEC_ONE) |=> done_r && state_r == BOS_IDLE;
  endproperty
  a_single_once: assert property (p_single_once) else $error("single transfer did not end");

  property p_rewind;
    ce && state_r == BOS_REWIND && last |=> regs_r.pc == 16'($past(regs_r.pc) - 16'h0002);
  endproperty
  a_rewind: assert property (p_rewind) else $error("pc not rewound by two");

  property p_end_zero;
    s_wr_end ##0 (regs_r.count == 8'h00) |=> done_r && flags_r.z && flags_r.n;
  endproperty
  a_end_zero: assert property (p_end_zero) else $error("zero count did not end with flags");

  property p_flag_single;
    s_wr_end ##0 (kind_r == BOS_K_DEC_ONE)
      |=> flags_r.z == ($past(regs_r.count) == 8'h00) && flags_r.c == $past(flags_r.c);
  endproperty
  a_flag_single: assert property (p_flag_single) else $error("single flags wrong");

  property p_rewind_len;
    s_wr_end ##0 (regs_r.count != `BOS_ZERO8 && repeating) ##1 ce [*5]
      |-> state_r == BOS_REWIND ##1 state_r != BOS_REWIND;
  endproperty
  a_rewind_len: assert property (p_rewind_len) else $error("rewind cycle too long");

endmodule : bos_out_seq

/* File: bos_bus_model.sv */
module bos_bus_model
  import bos_pkg::*;
(
  // clock
  input  wire logic       clk,
  // processor bus
  input  bos_bus_t        bus_i,
  output logic      [7:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] wr_addr[$];
  logic [7:0]  wr_data[$];
  int          n_rfsh;
  int          n_fetch;
  logic [15:0] fetch_addr;
  logic        wr_q;
  logic        rf_q;
  logic        fe_q;

  function automatic logic [7:0] mem_at(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : mem_at

  // undriven data bus shows inverted value, never a stale match
  assign mem_rdata_o = bus_i.mem_rd ? mem_at(bus_i.addr) : ~mem_at(bus_i.addr);

  initial
  begin
    wr_q   = 1'b0;
    rf_q   = 1'b0;
    fe_q   = 1'b0;
    n_rfsh = 0;
    n_fetch = 0;
    fetch_addr = 16'h0000;
  end

  // ----------------------------------------
  // record port writes and refresh cycles
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (bus_i.io_wr && !wr_q)
    begin
      wr_addr.push_back(bus_i.addr);
      wr_data.push_back(bus_i.dout);
    end
    if (bus_i.rfsh && !rf_q)
      n_rfsh++;
    // one fetch burst per instruction pass, address of its prefix byte
    if (bus_i.fetch && !fe_q)
    begin
      n_fetch++;
      fetch_addr = bus_i.addr;
    end
    wr_q = bus_i.io_wr;
    rf_q = bus_i.rfsh;
    fe_q = bus_i.fetch;
  end
endmodule : bos_bus_model

/* File: tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import bos_pkg::*;

  logic       clk;
  logic       arst_n;
  logic       ce;
  logic       start;
  logic       int_req;
  logic [7:0] prefix;
  logic [7:0] opcode;
  logic [7:0] mem_rdata;
  bos_regs_t  regs_in;
  bos_regs_t  regs_out;
  bos_flags_t flags_in;
  bos_flags_t flags_out;
  bos_bus_t   bus;
  logic       int_ack;
  logic       busy;
  logic       done;
  int         failures;
  int         n_tests;
  int         cyc;
  logic       ack;

  bos_out_seq u_dut (.clk(clk), .arst_n(arst_n), .ce(ce), .start_i(start), .prefix_i(prefix),
    .opcode_i(opcode), .regs_i(regs_in), .flags_i(flags_in), .mem_rdata_i(mem_rdata), .bus_o(bus),
    .int_req_i(int_req), .int_ack_o(int_ack), .busy_o(busy), .done_o(done), .regs_o(regs_out),
    .flags_o(flags_out));

  bos_bus_model u_mdl (.clk(clk), .bus_i(bus), .mem_rdata_o(mem_rdata));

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  // start held high while busy must not restart
  task automatic run(input logic [7:0] op, input logic [7:0] cnt, input logic [15:0] ptr, input logic irq,
                     input int gap);
    u_mdl.wr_addr.delete();
    u_mdl.wr_data.delete();
    u_mdl.n_rfsh = 0;
    u_mdl.n_fetch = 0;
    @(posedge clk);
    start    <= 1'b1;
    prefix   <= 8'hed;
    opcode   <= op;
    int_req  <= irq;
    regs_in  <= {cnt, 8'h07, ptr, 16'h0200};
    flags_in <= 6'h01;
    repeat (3) @(posedge clk);
    start <= 1'b0;
    // cyc numbers the next edge, the take edge being 0
    cyc = 2;
    ack = 1'b0;
    // clock enable gap freezes the sequencer for gap edges
    if (gap > 0)
    begin
      ce <= 1'b0;
      repeat (gap) @(posedge clk);
      ce <= 1'b1;
      cyc = 2 + gap;
    end
    while (cyc < 6000 && done !== 1'b1)
    begin
      @(negedge clk);
      cyc++;
      ack |= int_ack;
    end
    chk(busy, 0);
  endtask : run

  task automatic t_refuse();
    run(8'ha3, 8'h05, 16'h1000, 1'b0, 0);
    chk(u_mdl.wr_addr.size(), 0);
    chk(u_mdl.n_fetch, 0);
  endtask : t_refuse

  task automatic t_single(input logic [7:0] cnt, input logic z);
    run(8'hab, cnt, 16'h1000, 1'b0, 0);
    chk(cyc, 17);
    chk(u_mdl.wr_addr.size(), 1);
    chk(u_mdl.wr_addr[0], {cnt - 8'h01, 8'h07});
    chk(u_mdl.wr_data[0], u_mdl.mem_at(16'h1000));
    chk(regs_out, {cnt - 8'h01, 8'h07, 16'h0fff, 16'h0202});
    chk({flags_out.z, flags_out.n, flags_out.c}, {z, 2'b11});
    chk(u_mdl.n_rfsh, 2);
    chk(u_mdl.n_fetch, 1);
  endtask : t_single

  task automatic t_rpt(input logic [7:0] op, input logic [7:0] cnt, input logic [15:0] ptr,
                       input logic [15:0] step);
    int          n;
    logic [15:0] a;
    n = (cnt == 8'h00) ? 256 : int'(cnt);
    a = ptr;
    run(op, cnt, ptr, 1'b0, 0);
    chk(cyc, 16 + 21 * (n - 1) + 1);
    chk(u_mdl.wr_addr.size(), n);
    for (int i = 0; i < n && i < u_mdl.wr_addr.size(); i++)
    begin
      chk(u_mdl.wr_addr[i], {cnt - 8'(i + 1), 8'h07});
      chk(u_mdl.wr_data[i], u_mdl.mem_at(a));
      a = a + step;
    end
    chk(regs_out, {8'h00, 8'h07, a, 16'h0202});
    chk({flags_out.z, flags_out.n, flags_out.c}, 3'h7);
    chk(u_mdl.n_rfsh, 2 * n);
    chk(u_mdl.n_fetch, n);
    chk(u_mdl.fetch_addr, 16'h0200);
  endtask : t_rpt

  task automatic t_irq();
    run(8'hbb, 8'h03, 16'h1000, 1'b1, 0);
    chk(cyc, 22);
    chk(ack, 1);
    chk(u_mdl.wr_addr.size(), 1);
    chk(regs_out, {8'h02, 8'h07, 16'h0fff, 16'h0200});
    chk(u_mdl.n_fetch, 1);
  endtask : t_irq

  task automatic t_freeze();
    run(8'hab, 8'h05, 16'h1000, 1'b0, 7);
    chk(cyc, 24);
    chk(u_mdl.wr_addr.size(), 1);
    chk(u_mdl.wr_data[0], u_mdl.mem_at(16'h1000));
    chk(regs_out, {8'h04, 8'h07, 16'h0fff, 16'h0202});
    chk(u_mdl.n_rfsh, 2);
  endtask : t_freeze

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #(20000 * 40);
    failures++;
    end_sim();
  end

  initial
  begin
    failures = 0;
    n_tests  = 0;
    arst_n   = 1'b0;
    ce       = 1'b1;
    start    = 1'b0;
    int_req  = 1'b0;
    prefix   = 8'h00;
    opcode   = 8'h00;
    regs_in  = '0;
    flags_in = '0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_refuse();
    t_single(8'h10, 1'b0);
    t_single(8'h01, 1'b1);
    t_freeze();
    t_rpt(8'hb3, 8'h03, 16'h1000, 16'h0001);
    t_rpt(8'hbb, 8'h03, 16'h1000, 16'hffff);
    t_irq();
    t_rpt(8'hbb, 8'h00, 16'h2000, 16'hffff);
    end_sim();
  end
endmodule : tb
